// ### hdl/eie_core.sv
`include "eie_map.svh"
module eie_core
	import eie_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output eie_mem_req_type mem_req,
	input wire eie_mem_rsp_type mem_rsp
);
	eie_regs_type st_q;
	eie_regs_type st_d;
	logic [19:0] mask, opnd, sxt_res, xor_res;
	logic [20:0] add_sum;
	logic is_alu, is_jump, mem_phase;

	// Most significant bit at the selected size
	function automatic logic top_bit(input logic [19:0] v,
		input logic [1:0] sz);
		top_bit = (sz == `EIE_SZ_B) ? v[7] : (sz == `EIE_SZ_W) ? v[15]
			: v[19];
	endfunction : top_bit

	// Whether an operation reads memory before it executes
	function automatic logic mem_phase_d(input eie_regs_type s);
		mem_phase_d = (s.dst_mem && (s.op == `EIE_OP_SXT ||
			s.op == `EIE_OP_TST || s.op == `EIE_OP_XOR)) ||
			(s.op == `EIE_OP_RET) || ((s.op == `EIE_OP_BRA ||
			s.op == `EIE_OP_CALL) && s.mode > `EIE_MD_IMM);
	endfunction : mem_phase_d

	// First read address; only meaningful when a memory phase follows
	function automatic logic [19:0] launch_addr(input eie_regs_type s);
		logic [19:0] sidx;
		sidx = {{4{s.idx[15]}}, s.idx};
		launch_addr = (s.op == `EIE_OP_RET) ? s.sp
			: (s.op != `EIE_OP_BRA && s.op != `EIE_OP_CALL) ? s.dst
			: (s.mode == `EIE_MD_IDX) ? s.src + sidx
			: (s.mode == `EIE_MD_SYM) ? s.pc + sidx : s.src;
	endfunction : launch_addr

	// Register read-back
	function automatic logic [31:0] read_reg(input eie_regs_type s,
		input logic [7:0] a);
		read_reg = 32'h00000000;
		unique case (a)
			`EIE_OFS_CTRL: read_reg[`EIE_CTRL_DMEM:0] = {s.dst_mem, s.mode,
				s.size, s.op};
			`EIE_OFS_SRC: read_reg[19:0] = s.src;
			`EIE_OFS_DST: read_reg[19:0] = s.dst;
			`EIE_OFS_IDX: read_reg[15:0] = s.idx;
			`EIE_OFS_PC: read_reg[19:0] = s.pc;
			`EIE_OFS_SP: read_reg[19:0] = s.sp;
			`EIE_OFS_SR: read_reg[15:0] = s.sr;
			`EIE_OFS_RES: read_reg[19:0] = s.res;
			`EIE_OFS_STAT: read_reg[`EIE_STAT_ERR:0] = {s.err, s.done,
				s.state != ST_IDLE};
			`EIE_OFS_PTR: read_reg[19:0] = s.ptr;
			default: read_reg = 32'h00000000;
		endcase
	endfunction : read_reg

	// Known register offsets
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a <= `EIE_OFS_PTR) && (a[1:0] == 2'h0);
	endfunction : mapped

	// Datapath terms
	assign mask = (st_q.size == `EIE_SZ_B) ? 20'h000FF
		: (st_q.size == `EIE_SZ_W) ? 20'h0FFFF : 20'hFFFFF;
	assign opnd = st_q.dst_mem ? {st_q.tmp[19:16], st_q.tmp[15:0]} & mask
		: st_q.dst & mask;
	assign add_sum = {1'b0, st_q.src} + {1'b0, st_q.dst};
	assign xor_res = (st_q.src ^ opnd) & mask;
	assign is_alu = (st_q.op == `EIE_OP_SXT) || (st_q.op == `EIE_OP_TST) ||
		(st_q.op == `EIE_OP_XOR);
	assign is_jump = (st_q.op == `EIE_OP_BRA) || (st_q.op == `EIE_OP_CALL);

	// Sign-extended result: register form fills 19:8, memory per size
	assign sxt_res = !st_q.dst_mem ? {{12{st_q.dst[7]}}, st_q.dst[7:0]}
		: (st_q.size == `EIE_SZ_A) ? {{12{st_q.tmp[7]}}, st_q.tmp[7:0]}
		: {4'h0, {8{st_q.tmp[7]}}, st_q.tmp[7:0]};

	// Whether the running operation fetched from memory
	assign mem_phase = mem_phase_d(st_q);

	// Next state: bus slave, then sequencer
	always_comb begin
		logic [31:0] wv, old;
		wv = 32'h00000000;
		old = 32'h00000000;
		st_d = st_q;
		// Read channel: one outstanding read
		if (st_q.rvalid && s_axi_rready) begin
			st_d.rvalid = 1'b0;
		end
		if (!st_q.rvalid && s_axi_arvalid) begin
			st_d.rvalid = 1'b1;
			st_d.rdata = read_reg(st_q, s_axi_araddr);
			st_d.rresp = mapped(s_axi_araddr) ? `EIE_RESP_OKAY
				: `EIE_RESP_SLVERR;
		end
		// Write address and data taken in either order
		if (!st_q.aw_got && !st_q.bvalid && s_axi_awvalid) begin
			st_d.aw_got = 1'b1;
			st_d.awaddr = s_axi_awaddr;
		end
		if (!st_q.w_got && !st_q.bvalid && s_axi_wvalid) begin
			st_d.w_got = 1'b1;
			st_d.wdata = s_axi_wdata;
			st_d.wstrb = s_axi_wstrb;
		end
		if (st_q.bvalid && s_axi_bready) begin
			st_d.bvalid = 1'b0;
		end
		// Sequencer
		unique case (st_q.state)
			ST_IDLE: begin
			end
			ST_RD_LO: if (mem_rsp.ack) begin
				st_d.tmp[15:0] = mem_rsp.rdata;
				st_d.addr = st_q.addr + `EIE_WORD_STEP;
				st_d.state = (is_alu && st_q.size != `EIE_SZ_A) ? ST_EXEC
					: ST_RD_HI;
			end
			ST_RD_HI: if (mem_rsp.ack) begin
				st_d.tmp[31:16] = mem_rsp.rdata;
				st_d.state = ST_EXEC;
			end
			ST_EXEC: begin
				st_d.state = ST_IDLE;
				st_d.done = 1'b1;
				unique case (st_q.op)
					`EIE_OP_SXT, `EIE_OP_TST, `EIE_OP_XOR: begin
						if (st_q.op == `EIE_OP_SXT) begin
							st_d.res = sxt_res;
							st_d.sr[`EIE_SR_V] = 1'b0;
							st_d.sr[`EIE_SR_Z] = ((sxt_res & mask) == 20'h00000);
						end else if (st_q.op == `EIE_OP_TST) begin
							st_d.res = opnd;
							st_d.sr[`EIE_SR_V] = 1'b0;
							st_d.sr[`EIE_SR_Z] = (opnd == 20'h00000);
						end else begin
							st_d.res = xor_res;
							st_d.sr[`EIE_SR_V] = top_bit(st_q.src, st_q.size) &
								top_bit(opnd, st_q.size);
							st_d.sr[`EIE_SR_Z] = (xor_res == 20'h00000);
						end
						st_d.sr[`EIE_SR_N] = top_bit(st_d.res, st_q.size);
						st_d.sr[`EIE_SR_C] = (st_q.op == `EIE_OP_TST) ? 1'b1
							: !st_d.sr[`EIE_SR_Z];
						if (st_q.op != `EIE_OP_TST) begin
							if (st_q.dst_mem) begin
								st_d.addr = st_q.dst;
								st_d.mwe = 1'b1;
								st_d.mwdata = (st_q.size == `EIE_SZ_B)
									? {st_q.tmp[15:8], st_d.res[7:0]}
									: st_d.res[15:0];
								st_d.state = ST_WR_LO;
								st_d.done = 1'b0;
							end else begin
								st_d.res = (st_q.op == `EIE_OP_SXT) ? st_d.res
									: st_d.res & mask;
								st_d.dst = st_d.res;
							end
						end
					end
					`EIE_OP_ADD_ADDRESS_REG: if (st_q.mode <= `EIE_MD_IMM) begin
						st_d.res = add_sum[19:0];
						st_d.dst = add_sum[19:0];
						st_d.sr[`EIE_SR_N] = add_sum[19];
						st_d.sr[`EIE_SR_Z] = (add_sum[19:0] == 20'h00000);
						st_d.sr[`EIE_SR_C] = add_sum[20];
						st_d.sr[`EIE_SR_V] = (st_q.src[19] == st_q.dst[19]) &&
							(add_sum[19] != st_q.src[19]);
					end else begin
						st_d.err = 1'b1;
					end
					`EIE_OP_BRA, `EIE_OP_CALL: begin
						st_d.res = mem_phase ? {st_q.tmp[19:16], st_q.tmp[15:0]}
							: st_q.src;
						if (st_q.mode == `EIE_MD_AINC) begin
							st_d.ptr = st_q.src + `EIE_PTR_STEP;
						end
						if (st_q.op == `EIE_OP_CALL) begin
							st_d.sp = st_q.sp - `EIE_WORD_STEP;
							st_d.addr = st_q.sp - `EIE_WORD_STEP;
							st_d.mwe = 1'b1;
							st_d.mwdata = {12'h000, st_q.pc[19:16]};
							st_d.state = ST_PUSH_HI;
							st_d.done = 1'b0;
						end else begin
							st_d.pc = st_d.res;
						end
					end
					`EIE_OP_RET: begin
						st_d.pc = {st_q.tmp[19:16], st_q.tmp[15:0]};
						st_d.sp = st_q.sp + `EIE_PTR_STEP;
					end
					default: st_d.err = 1'b1;
				endcase
			end
			ST_WR_LO: if (mem_rsp.ack) begin
				st_d.addr = st_q.addr + `EIE_WORD_STEP;
				st_d.mwdata = {12'h000, st_q.res[19:16]};
				st_d.state = (st_q.size == `EIE_SZ_A) ? ST_WR_HI : ST_IDLE;
				st_d.done = (st_q.size != `EIE_SZ_A);
			end
			ST_WR_HI: if (mem_rsp.ack) begin
				st_d.state = ST_IDLE;
				st_d.done = 1'b1;
			end
			ST_PUSH_HI: if (mem_rsp.ack) begin
				st_d.sp = st_q.sp - `EIE_WORD_STEP;
				st_d.addr = st_q.sp - `EIE_WORD_STEP;
				st_d.mwdata = st_q.pc[15:0];
				st_d.state = ST_PUSH_LO;
			end
			ST_PUSH_LO: if (mem_rsp.ack) begin
				st_d.pc = st_q.res;
				st_d.state = ST_IDLE;
				st_d.done = 1'b1;
			end
		endcase
		// Register write once address and data are both held
		if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
			st_d.aw_got = 1'b0;
			st_d.w_got = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = mapped(st_q.awaddr) ? `EIE_RESP_OKAY
				: `EIE_RESP_SLVERR;
			old = read_reg(st_q, st_q.awaddr);
			for (int i = 0; i < 4; i++) begin
				wv[i*8 +: 8] = st_q.wstrb[i] ? st_q.wdata[i*8 +: 8]
					: old[i*8 +: 8];
			end
			// Writes land only while the sequencer is idle
			if (st_q.state == ST_IDLE) begin
				unique case (st_q.awaddr)
					`EIE_OFS_CTRL: {st_d.dst_mem, st_d.mode, st_d.size, st_d.op} =
						wv[`EIE_CTRL_DMEM:0];
					`EIE_OFS_SRC: st_d.src = wv[19:0];
					`EIE_OFS_DST: st_d.dst = wv[19:0];
					`EIE_OFS_IDX: st_d.idx = wv[15:0];
					`EIE_OFS_PC: st_d.pc = wv[19:0];
					`EIE_OFS_SP: st_d.sp = wv[19:0];
					`EIE_OFS_SR: st_d.sr = wv[15:0];
					`EIE_OFS_PTR: st_d.ptr = wv[19:0];
					default: begin
					end
				endcase
				if (st_q.awaddr == `EIE_OFS_CTRL && st_q.wstrb[3] &&
					st_q.wdata[`EIE_CTRL_START]) begin
					st_d.done = 1'b0;
					st_d.err = 1'b0;
					st_d.state = ST_EXEC;
				end
			end
		end
		// Launch: operations with memory operands fetch them first
		if (st_q.state == ST_IDLE && st_d.state == ST_EXEC &&
			mem_phase_d(st_d)) begin
			st_d.state = ST_RD_LO;
			st_d.mwe = 1'b0;
			st_d.addr = launch_addr(st_d);
		end
		if (!resetn) begin
			st_d = '0;
			st_d.state = ST_IDLE;
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		st_q <= st_d;
	end

	// Port drive
	assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
	assign s_axi_wready = !st_q.w_got && !st_q.bvalid;
	assign s_axi_bvalid = st_q.bvalid;
	assign s_axi_bresp = st_q.bresp;
	assign s_axi_arready = !st_q.rvalid;
	assign s_axi_rvalid = st_q.rvalid;
	assign s_axi_rdata = st_q.rdata;
	assign s_axi_rresp = st_q.rresp;
	assign mem_req.req = (st_q.state != ST_IDLE) && (st_q.state != ST_EXEC);
	assign mem_req.we = st_q.mwe && (st_q.state != ST_RD_LO) &&
		(st_q.state != ST_RD_HI);
	assign mem_req.addr = st_q.addr;
	assign mem_req.wdata = st_q.mwdata;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_sxt_reg_fill: assert property (
		(st_q.state == ST_EXEC && st_q.op == `EIE_OP_SXT && !st_q.dst_mem)
		|=> st_q.dst[19:8] == {12{$past(st_q.dst[7])}})
		else $error("register sign fill wrong");
	a_sxt_hi_clear: assert property (
		(st_q.state == ST_WR_HI) |-> mem_req.wdata[15:4] == 12'h000)
		else $error("upper address-word bits not cleared");
	a_sxt_word_fill: assert property (
		(st_q.state == ST_EXEC && st_q.op == `EIE_OP_SXT && st_q.dst_mem &&
		st_q.size == `EIE_SZ_W) |=> st_q.res[19:8] ==
		{4'h0, {8{$past(st_q.tmp[7])}}})
		else $error("word sign fill wrong");
	a_carry_not_zero: assert property (
		(st_q.state == ST_EXEC && (st_q.op == `EIE_OP_SXT ||
		st_q.op == `EIE_OP_XOR)) |=> st_q.sr[`EIE_SR_C] != st_q.sr[`EIE_SR_Z])
		else $error("carry is not inverse of zero");
	a_mode_bits_kept: assert property (
		(st_q.state != ST_IDLE) |=> $stable(st_q.sr[`EIE_SR_MODE]))
		else $error("mode bits changed by execution");
	a_test_flags: assert property (
		(st_q.state == ST_EXEC && st_q.op == `EIE_OP_TST) |=>
		st_q.sr[`EIE_SR_C] && !st_q.sr[`EIE_SR_V] && $stable(st_q.dst))
		else $error("test flags wrong");
	a_add_carry: assert property (
		(st_q.state == ST_EXEC && st_q.op == `EIE_OP_ADD_ADDRESS_REG &&
		st_q.mode == `EIE_MD_REG) |=> st_q.sr[`EIE_SR_C] == $past(add_sum[20]))
		else $error("add carry wrong");
	a_call_push: assert property (
		(st_q.state == ST_PUSH_HI && mem_rsp.ack) |=>
		st_q.state == ST_PUSH_LO &&
		mem_req.addr == $past(mem_req.addr) - `EIE_WORD_STEP)
		else $error("call push order wrong");
	a_ptr_step: assert property (
		(st_q.state == ST_EXEC && is_jump && st_q.mode == `EIE_MD_AINC) |=>
		st_q.ptr == $past(st_q.src) + `EIE_PTR_STEP)
		else $error("pointer not advanced by four");
	a_jump_flags: assert property (
		(st_q.state == ST_EXEC && is_jump) |=> $stable(st_q.sr))
		else $error("branch changed flags");
endmodule : eie_core

// ### common/eie_map.svh
`ifndef EIE_MAP_SVH
`define EIE_MAP_SVH
// Register byte offsets
`define EIE_OFS_CTRL 8'h00
`define EIE_OFS_SRC 8'h04
`define EIE_OFS_DST 8'h08
`define EIE_OFS_IDX 8'h0C
`define EIE_OFS_PC 8'h10
`define EIE_OFS_SP 8'h14
`define EIE_OFS_SR 8'h18
`define EIE_OFS_RES 8'h1C
`define EIE_OFS_STAT 8'h20
`define EIE_OFS_PTR 8'h24
// Control register fields
`define EIE_CTRL_OP 3:0
`define EIE_CTRL_SIZE 5:4
`define EIE_CTRL_MODE 8:6
`define EIE_CTRL_DMEM 9
`define EIE_CTRL_START 31
// Status register of the block
`define EIE_STAT_BUSY 0
`define EIE_STAT_DONE 1
`define EIE_STAT_ERR 2
// Operation codes
`define EIE_OP_SXT 4'h1
`define EIE_OP_TST 4'h2
`define EIE_OP_XOR 4'h3
`define EIE_OP_ADD_ADDRESS_REG 4'h4
`define EIE_OP_BRA 4'h5
`define EIE_OP_CALL 4'h6
`define EIE_OP_RET 4'h7
// Operand sizes
`define EIE_SZ_A 2'h0
`define EIE_SZ_W 2'h1
`define EIE_SZ_B 2'h2
// Source addressing modes
`define EIE_MD_REG 3'h0
`define EIE_MD_IMM 3'h1
`define EIE_MD_IND 3'h2
`define EIE_MD_AINC 3'h3
`define EIE_MD_IDX 3'h4
`define EIE_MD_SYM 3'h5
`define EIE_MD_ABS 3'h6
// CPU status word bits
`define EIE_SR_C 0
`define EIE_SR_Z 1
`define EIE_SR_N 2
`define EIE_SR_MODE 5:3
`define EIE_SR_V 8
// Step sizes and bus answers
`define EIE_WORD_STEP 20'h00002
`define EIE_PTR_STEP 20'h00004
`define EIE_RESP_OKAY 2'h0
`define EIE_RESP_SLVERR 2'h2
`endif

// ### common/eie_pkg.sv
package eie_pkg;
	// Execution sequencer, one-hot
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_RD_LO = 8'h02,
		ST_RD_HI = 8'h04,
		ST_EXEC = 8'h08,
		ST_WR_LO = 8'h10,
		ST_WR_HI = 8'h20,
		ST_PUSH_HI = 8'h40,
		ST_PUSH_LO = 8'h80
	} eie_state_type;
	// Memory request towards program, data and stack memory
	typedef struct packed {
		logic req;
		logic we;
		logic [19:0] addr;
		logic [15:0] wdata;
	} eie_mem_req_type;
	// Memory answer
	typedef struct packed {
		logic ack;
		logic [15:0] rdata;
	} eie_mem_rsp_type;
	// Whole state of the block
	typedef struct packed {
		eie_state_type state;
		logic [3:0] op;
		logic [1:0] size;
		logic [2:0] mode;
		logic dst_mem;
		logic [19:0] src;
		logic [19:0] dst;
		logic [15:0] idx;
		logic [19:0] pc;
		logic [19:0] sp;
		logic [15:0] sr;
		logic [19:0] res;
		logic [19:0] ptr;
		logic [19:0] addr;
		logic [31:0] tmp;
		logic done;
		logic err;
		logic mwe;
		logic [15:0] mwdata;
		logic aw_got;
		logic [7:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} eie_regs_type;
endpackage : eie_pkg

// ### sim/eie_mem_model.sv
module eie_mem_model
	import eie_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic slow,
	input wire eie_mem_req_type mem_req,
	output eie_mem_rsp_type mem_rsp
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************
	// Storage and access log
	// ****************************************
	logic [15:0] mem [logic [19:0]];
	logic [36:0] log_q [$];
	logic [1:0] wait_q;

	// Preload a word from the bench
	task poke(input logic [19:0] a, input logic [15:0] d);
		mem[a] = d;
	endtask : poke

	// Look at a word without a bus cycle
	function logic [15:0] peek(input logic [19:0] a);
		return mem.exists(a) ? mem[a] : 16'h0000;
	endfunction : peek

	// ****************************************
	// Word answer, prompt or after three waits
	// ****************************************
	// Data line shows the inverse of the last value outside a read answer
	always @(posedge sys_clk) begin
		if (!resetn) begin
			mem_rsp.ack <= 1'b0;
			mem_rsp.rdata <= 16'h0000;
			wait_q <= 2'h0;
		end else if (mem_req.req && !mem_rsp.ack && (!slow || wait_q == 2'h3)) begin
			mem_rsp.ack <= 1'b1;
			wait_q <= 2'h0;
			if (mem_req.we) begin
				mem[mem_req.addr] = mem_req.wdata;
				mem_rsp.rdata <= ~mem_rsp.rdata;
				log_q.push_back({1'b1, mem_req.addr, mem_req.wdata});
			end else begin
				mem_rsp.rdata <= peek(mem_req.addr);
				log_q.push_back({1'b0, mem_req.addr, 16'h0000});
			end
		end else begin
			mem_rsp.ack <= 1'b0;
			mem_rsp.rdata <= ~mem_rsp.rdata;
			wait_q <= (mem_req.req && slow) ? wait_q + 2'h1 : 2'h0;
		end
	end
endmodule : eie_mem_model

// ### sim/extended_insn_execute_tb.sv
`include "eie_map.svh"
module extended_insn_execute_tb
	import eie_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************
	// Signals and instances
	// ****************************************
	typedef struct packed {
		logic [31:0] ctrl;
		logic [19:0] src, dst;
		logic [15:0] idx, sr;
		logic [7:0] ofs;
		logic [19:0] exp;
		logic [15:0] esr;
	} eie_row_type;
	logic sys_clk, resetn, slow;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	eie_mem_req_type mem_req;
	eie_mem_rsp_type mem_rsp;
	eie_row_type rows [$];
	int err_count, tests_run;
	localparam logic [35:0] PRE [10] = '{36'h01000_5678, 36'h01002_0003,
		36'h01004_ABCD, 36'h01006_FFFA, 36'h01FF0_1111, 36'h01FF2_0004,
		36'h03010_2222, 36'h03012_0005, 36'h04000_3333, 36'h04002_0006};

	eie_core uut (.sys_clk(sys_clk), .resetn(resetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .mem_req(mem_req), .mem_rsp(mem_rsp));
	eie_mem_model u_mem (.sys_clk(sys_clk), .resetn(resetn), .slow(slow),
		.mem_req(mem_req), .mem_rsp(mem_rsp));

	// Clock at 40 MHz
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// ****************************************
	// Checking and bus tasks
	// ****************************************
	task end_of_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test

	task chk_val(input string name, input logic [39:0] exp, got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk_val

	// A wait that ran out ends the run
	task give_up(input string name);
		err_count++;
		$display("wrong value %s expected answer seen timeout", name);
		end_of_test();
	endtask : give_up

	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		if (n == 60) give_up("write response");
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task axi_rd(input logic [7:0] a);
		int n;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		if (n == 60) give_up("read data");
		v = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	function logic [31:0] ctl(input logic [3:0] op, input logic [1:0] sz,
		input logic [2:0] md, input logic dm);
		return {1'b1, 21'h0, dm, md, sz, op};
	endfunction : ctl

	// Load operands, start, wait until idle with done or error
	task run_op(input logic [31:0] c, input logic [19:0] s, d,
		input logic [15:0] x, input logic [19:0] pc, sp, input logic [15:0] sr);
		int n;
		axi_wr(`EIE_OFS_SRC, {12'h0, s});
		axi_wr(`EIE_OFS_DST, {12'h0, d});
		axi_wr(`EIE_OFS_IDX, {16'h0, x});
		axi_wr(`EIE_OFS_PC, {12'h0, pc});
		axi_wr(`EIE_OFS_SP, {12'h0, sp});
		axi_wr(`EIE_OFS_SR, {16'h0, sr});
		axi_wr(`EIE_OFS_CTRL, c);
		for (n = 0; n < 80; n++) begin
			axi_rd(`EIE_OFS_STAT);
			if (v[`EIE_STAT_BUSY] === 1'b0 && v[2:1] != 2'b00) break;
		end
		if (n == 80) give_up("operation end");
	endtask : run_op

	task rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
		axi_rd(a);
		chk_val(name, e, v);
	endtask : rd_chk

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		resetn = 1'b0;
		slow = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
		{s_axi_arvalid, s_axi_rready} = 2'b00;
		err_count = 0;
		tests_run = 0;
		for (int i = 0; i < 10; i++) u_mem.poke(PRE[i][35:16], PRE[i][15:0]);
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		// Reset values and unmapped places
		rd_chk("stat reset", `EIE_OFS_STAT, 32'h0);
		rd_chk("sr reset", `EIE_OFS_SR, 32'h0);
		axi_rd(8'h28);
		chk_val("unmapped read", {v, r}, {32'h0, `EIE_RESP_SLVERR});
		axi_wr(8'h3C, 32'h1234);
		chk_val("unmapped write", r, `EIE_RESP_SLVERR);
		// Table of register operations
		rows.push_back({ctl(`EIE_OP_SXT, `EIE_SZ_A, `EIE_MD_REG, 1'b0),
			20'h0, 20'h12380, 16'h0, 16'h0138, `EIE_OFS_RES, 20'hFFF80, 16'h003D});
		rows.push_back({ctl(`EIE_OP_SXT, `EIE_SZ_A, `EIE_MD_REG, 1'b0),
			20'h0, 20'hAB100, 16'h0, 16'h0139, `EIE_OFS_RES, 20'h00000, 16'h003A});
		rows.push_back({ctl(`EIE_OP_TST, `EIE_SZ_A, `EIE_MD_REG, 1'b0),
			20'h0, 20'h80000, 16'h0, 16'h0100, `EIE_OFS_DST, 20'h80000, 16'h0005});
		rows.push_back({ctl(`EIE_OP_TST, `EIE_SZ_B, `EIE_MD_REG, 1'b0),
			20'h0, 20'hFFF00, 16'h0, 16'h0038, `EIE_OFS_DST, 20'hFFF00, 16'h003B});
		rows.push_back({ctl(`EIE_OP_XOR, `EIE_SZ_A, `EIE_MD_REG, 1'b0),
			20'h80001, 20'h80003, 16'h0, 16'h0038, `EIE_OFS_RES, 20'h2, 16'h0139});
		rows.push_back({ctl(`EIE_OP_XOR, `EIE_SZ_W, `EIE_MD_REG, 1'b0),
			20'h0F0F0, 20'hF0F0F, 16'h0, 16'h0138, `EIE_OFS_RES, 20'h0FFFF, 16'h3D});
		rows.push_back({ctl(`EIE_OP_XOR, `EIE_SZ_B, `EIE_MD_REG, 1'b0),
			20'h00055, 20'h12355, 16'h0, 16'h0107, `EIE_OFS_DST, 20'h0, 16'h0002});
		rows.push_back({ctl(`EIE_OP_SXT, `EIE_SZ_W, `EIE_MD_REG, 1'b0),
			20'h0, 20'h12380, 16'h0, 16'h0038, `EIE_OFS_DST, 20'hFFF80, 16'h003D});
		rows.push_back({ctl(`EIE_OP_XOR, `EIE_SZ_B, `EIE_MD_REG, 1'b0),
			20'h00080, 20'h00081, 16'h0, 16'h0038, `EIE_OFS_SRC, 20'h80, 16'h0139});
		rows.push_back({ctl(`EIE_OP_ADD_ADDRESS_REG, `EIE_SZ_A, `EIE_MD_REG, 1'b0),
			20'h80000, 20'h80000, 16'h0, 16'h0038, `EIE_OFS_RES, 20'h0, 16'h013B});
		rows.push_back({ctl(`EIE_OP_ADD_ADDRESS_REG, `EIE_SZ_A, `EIE_MD_IMM, 1'b0),
			20'h7FFFF, 20'h1, 16'h0, 16'h0038, `EIE_OFS_RES, 20'h80000, 16'h013C});
		rows.push_back({ctl(`EIE_OP_BRA, `EIE_SZ_A, `EIE_MD_REG, 1'b0),
			20'h12345, 20'h0, 16'h0, 16'h013F, `EIE_OFS_PC, 20'h12345, 16'h013F});
		rows.push_back({ctl(`EIE_OP_BRA, `EIE_SZ_A, `EIE_MD_IMM, 1'b0),
			20'h6789A, 20'h0, 16'h0, 16'h0107, `EIE_OFS_PC, 20'h6789A, 16'h0107});
		rows.push_back({ctl(`EIE_OP_BRA, `EIE_SZ_A, `EIE_MD_IND, 1'b0),
			20'h01000, 20'h0, 16'h0, 16'h0106, `EIE_OFS_PC, 20'h35678, 16'h0106});
		rows.push_back({ctl(`EIE_OP_BRA, `EIE_SZ_A, `EIE_MD_IDX, 1'b0),
			20'h02000, 20'h0, 16'hFFF0, 16'h0, `EIE_OFS_PC, 20'h41111, 16'h0});
		rows.push_back({ctl(`EIE_OP_BRA, `EIE_SZ_A, `EIE_MD_SYM, 1'b0),
			20'h0, 20'h0, 16'h0010, 16'h013F, `EIE_OFS_PC, 20'h52222, 16'h013F});
		rows.push_back({ctl(`EIE_OP_BRA, `EIE_SZ_A, `EIE_MD_ABS, 1'b0),
			20'h04000, 20'h0, 16'h0, 16'h0005, `EIE_OFS_PC, 20'h63333, 16'h0005});
		rows.push_back({ctl(`EIE_OP_CALL, `EIE_SZ_A, `EIE_MD_IDX, 1'b0),
			20'h02000, 20'h0, 16'hFFF0, 16'h0138, `EIE_OFS_PC, 20'h41111, 16'h138});
		foreach (rows[i]) begin
			run_op(rows[i].ctrl, rows[i].src, rows[i].dst, rows[i].idx,
				20'h03000, 20'h00400, rows[i].sr);
			rd_chk("row value", rows[i].ofs, {12'h0, rows[i].exp});
			rd_chk("row status", `EIE_OFS_SR, {16'h0, rows[i].esr});
		end
		// Call through auto-increment pointer with a slow memory
		slow <= 1'b1;
		u_mem.log_q.delete();
		run_op(ctl(`EIE_OP_CALL, `EIE_SZ_A, `EIE_MD_AINC, 1'b0), 20'h01004,
			20'h0, 16'h0, 20'h5ABCD, 20'h00400, 16'h013F);
		chk_val("fetch low", {1'b0, 20'h01004, 16'h0}, u_mem.log_q[0]);
		chk_val("fetch high", {1'b0, 20'h01006, 16'h0}, u_mem.log_q[1]);
		chk_val("push high", {1'b1, 20'h003FE, 16'h0005}, u_mem.log_q[2]);
		chk_val("push low", {1'b1, 20'h003FC, 16'hABCD}, u_mem.log_q[3]);
		rd_chk("call pc", `EIE_OFS_PC, 32'hAABCD);
		rd_chk("call sp", `EIE_OFS_SP, 32'h003FC);
		rd_chk("pointer", `EIE_OFS_PTR, 32'h01008);
		rd_chk("call sr", `EIE_OFS_SR, 32'h013F);
		// Return pops what the call pushed
		run_op(ctl(`EIE_OP_RET, `EIE_SZ_A, `EIE_MD_REG, 1'b0), 20'h0, 20'h0,
			16'h0, 20'h0, 20'h003FC, 16'h0FFF);
		rd_chk("ret pc", `EIE_OFS_PC, 32'h5ABCD);
		rd_chk("ret sp", `EIE_OFS_SP, 32'h00400);
		rd_chk("ret sr", `EIE_OFS_SR, 32'h0FFF);
		// Add with a memory source mode is refused
		run_op(ctl(`EIE_OP_ADD_ADDRESS_REG, `EIE_SZ_A, `EIE_MD_IND, 1'b0), 20'h1, 20'h2,
			16'h0, 20'h0, 20'h0, 16'h0038);
		chk_val("add refused", v[`EIE_STAT_ERR], 1'b1);
		rd_chk("add sr kept", `EIE_OFS_SR, 32'h0038);
		// Sign-extend of memory operands, address-word then word
		u_mem.poke(20'h05000, 16'h1280);
		u_mem.poke(20'h05002, 16'hFFFF);
		u_mem.poke(20'h05010, 16'h7F3C);
		u_mem.poke(20'h05012, 16'hBEEF);
		run_op(ctl(`EIE_OP_SXT, `EIE_SZ_A, `EIE_MD_REG, 1'b1), 20'h0, 20'h05000,
			16'h0, 20'h0, 20'h0, 16'h0038);
		chk_val("ext low", u_mem.peek(20'h05000), 16'hFF80);
		chk_val("ext high", u_mem.peek(20'h05002), 16'h000F);
		rd_chk("ext sr", `EIE_OFS_SR, 32'h003D);
		run_op(ctl(`EIE_OP_SXT, `EIE_SZ_W, `EIE_MD_REG, 1'b1), 20'h0, 20'h05010,
			16'h0, 20'h0, 20'h0, 16'h0038);
		chk_val("word low", u_mem.peek(20'h05010), 16'h003C);
		chk_val("word high", u_mem.peek(20'h05012), 16'hBEEF);
		rd_chk("word sr", `EIE_OFS_SR, 32'h0039);
		end_of_test();
	end
endmodule : extended_insn_execute_tb
